// [core/flash_cmd_map.svh]
// offsets, field positions, reset values and timing counts of the flash command host
`ifndef FLASH_CMD_MAP_SVH
`define FLASH_CMD_MAP_SVH

// software register byte offsets
`define REG_CMD 8'h00
`define REG_ADDR 8'h04
`define REG_DATA 8'h08
`define REG_DATA2 8'h0c
`define REG_STATUS 8'h10
`define REG_RDATA 8'h14
`define REG_CTRL 8'h18

// status register fields
`define ST_BUSY 0
`define ST_REFUSED 1
`define ST_ID_MODE 2
`define ST_PULSE_MODE 3
`define ST_QUERY_MODE 4
`define ST_BLOCK_B_LOCKED 5
`define ST_BLOCK_B_KNOWN 6

// control register fields and reset value
`define CTRL_FLASH_RESET 0
`define CTRL_RESET_VALUE 1'b0

// command field width in the command register
`define CMD_W 5

// flash bus widths and command field widths
`define FA_W 21
`define FD_W 16
`define CMD_ADDR_W 12
`define CMD_DATA_W 8

// fixed command addresses and data bytes
`define ADDR_UNLOCK1 12'h555
`define ADDR_UNLOCK2 12'haaa
`define ADDR_BLOCK_B 12'h080
`define ADDR_QUERY 12'h055
`define ADDR_ANY 12'h000
`define DATA_UNLOCK1 8'haa
`define DATA_UNLOCK2 8'h55
`define DATA_ERASE_SETUP 8'h80
`define DATA_CHIP_ERASE 8'h10
`define DATA_SECTOR_ERASE 8'h30
`define DATA_PROGRAM 8'ha0
`define DATA_DUAL_PROGRAM 8'he0
`define DATA_LOCKDOWN 8'h60
`define DATA_SUSPEND 8'hb0
`define DATA_RESUME 8'h30
`define DATA_ID_ENTRY 8'h90
`define DATA_ID_EXIT 8'hf0
`define DATA_PROT_PROGRAM 8'hc0
`define DATA_PROT_LOCK 8'h00
`define DATA_CONFIG 8'hd0
`define DATA_QUERY 8'h98
`define BLOCK_B_FLAG_BIT 1

// bus timing: least times, rounded up to whole clock cycles
`define CLK_PERIOD_NS 40
`define SETUP_NS 40
`define STROBE_NS 80
`define HOLD_NS 40
`define SETUP_CYCLES ((`SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_CYCLES ((`STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOLD_CYCLES ((`HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [core/flash_cmd_pkg.sv]
// types shared by the flash command host files
package flash_cmd_pkg;

   // command codes in the order software writes them
   typedef enum logic [4:0] {
      cmd_read, cmd_chip_erase, cmd_sector_erase, cmd_program, cmd_dual_program,
      cmd_enter_pulse, cmd_pulse_program, cmd_lockdown, cmd_suspend, cmd_resume,
      cmd_id_entry, cmd_id_exit_long, cmd_id_exit_short, cmd_prot_program,
      cmd_prot_lock, cmd_block_b_status, cmd_set_config, cmd_query
   } cmd_t;

   typedef enum logic [1:0] {asel_fixed, asel_target, asel_target2, asel_prot} addr_sel_t;
   typedef enum logic [1:0] {dsel_fixed, dsel_user, dsel_user2} data_sel_t;

   // one bus cycle of a command sequence
   typedef struct packed {
      addr_sel_t asel;
      data_sel_t dsel;
      logic [11:0] addr;
      logic [7:0] data;
      logic is_read;
      logic last;
   } step_t;

   // one request to the bus cycle engine
   typedef struct packed {
      logic is_read;
      logic [20:0] addr;
      logic [15:0] data;
   } bus_op_t;

   // flash pins driven by the host
   typedef struct packed {
      logic [20:0] addr;
      logic [15:0] dq;
      logic dq_oe_n;
      logic ce_n;
      logic we_n;
      logic oe_n;
   } flash_out_t;

endpackage

// [core/cmd_step_table.sv]
// table of bus cycles for every flash command sequence
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_map.svh"

module cmd_step_table
   import flash_cmd_pkg::*;
(
   input wire cmd_t cmd,
   input wire logic [2:0] step,
   output step_t entry
);

   // a fixed-address write of a command byte
   function automatic step_t fixed(input logic [11:0] a, input logic [7:0] d, input logic l);
      step_t r;
      r = '{asel: asel_fixed, dsel: dsel_fixed, addr: a, data: d, is_read: 1'b0, last: l};
      return r;
   endfunction

   // a cycle whose address comes from software and whose data source the caller picks
   function automatic step_t user(input addr_sel_t a, input data_sel_t d, input logic l);
      step_t r;
      r = '{asel: a, dsel: d, addr: `ADDR_ANY, data: 8'h00, is_read: 1'b0, last: l};
      return r;
   endfunction

   // byte sent in the third cycle of each unlocked command
   function automatic logic [7:0] third_byte(input cmd_t c);
      case (c)
         cmd_chip_erase, cmd_sector_erase, cmd_enter_pulse, cmd_lockdown: third_byte = `DATA_ERASE_SETUP;
         cmd_program: third_byte = `DATA_PROGRAM;
         cmd_dual_program: third_byte = `DATA_DUAL_PROGRAM;
         cmd_id_entry, cmd_block_b_status: third_byte = `DATA_ID_ENTRY;
         cmd_id_exit_long: third_byte = `DATA_ID_EXIT;
         cmd_prot_program, cmd_prot_lock: third_byte = `DATA_PROT_PROGRAM;
         cmd_set_config: third_byte = `DATA_CONFIG;
         default: third_byte = 8'h00;
      endcase
   endfunction

   // the second unlock always uses aaa; 2aa would decode the same
   always_comb begin
      entry = fixed(`ADDR_ANY, 8'h00, 1'b1);
      case (cmd)
         cmd_read: begin
            entry = user(asel_target, dsel_fixed, 1'b1);
            entry.is_read = 1'b1;
         end
         cmd_pulse_program: entry = user(asel_target, dsel_user, 1'b1);
         cmd_suspend: entry = fixed(`ADDR_ANY, `DATA_SUSPEND, 1'b1);
         cmd_resume: entry = fixed(`ADDR_ANY, `DATA_RESUME, 1'b1);
         cmd_id_exit_short: entry = fixed(`ADDR_ANY, `DATA_ID_EXIT, 1'b1);
         cmd_query: entry = fixed(`ADDR_QUERY, `DATA_QUERY, 1'b1);
         default: begin
            case (step)
               3'd0: entry = fixed(`ADDR_UNLOCK1, `DATA_UNLOCK1, 1'b0);
               3'd1: entry = fixed(`ADDR_UNLOCK2, `DATA_UNLOCK2, 1'b0);
               3'd2: entry = fixed(`ADDR_UNLOCK1, third_byte(cmd),
                                   (cmd == cmd_id_entry) || (cmd == cmd_id_exit_long));
               3'd3: begin
                  case (cmd)
                     cmd_program: entry = user(asel_target, dsel_user, 1'b1);
                     cmd_dual_program: entry = user(asel_target, dsel_user, 1'b0);
                     cmd_prot_program: entry = user(asel_prot, dsel_user, 1'b1);
                     cmd_prot_lock: entry = fixed(`ADDR_BLOCK_B, `DATA_PROT_LOCK, 1'b1);
                     cmd_set_config: entry = user(asel_target, dsel_user, 1'b1);
                     cmd_block_b_status: begin
                        entry = fixed(`ADDR_BLOCK_B, 8'h00, 1'b1);
                        entry.is_read = 1'b1;
                     end
                     default: entry = fixed(`ADDR_UNLOCK1, `DATA_UNLOCK1, 1'b0);
                  endcase
               end
               3'd4: begin
                  if (cmd == cmd_dual_program) begin
                     entry = user(asel_target2, dsel_user2, 1'b1);
                  end else begin
                     entry = fixed(`ADDR_UNLOCK2, `DATA_UNLOCK2, 1'b0);
                  end
               end
               default: begin
                  case (cmd)
                     cmd_chip_erase: entry = fixed(`ADDR_UNLOCK1, `DATA_CHIP_ERASE, 1'b1);
                     cmd_sector_erase: entry = user(asel_target, dsel_fixed, 1'b1);
                     cmd_lockdown: entry = user(asel_target, dsel_fixed, 1'b1);
                     default: entry = fixed(`ADDR_UNLOCK1, `DATA_PROGRAM, 1'b1);
                  endcase
                  entry.data = (cmd == cmd_lockdown) ? `DATA_LOCKDOWN :
                               (cmd == cmd_sector_erase) ? `DATA_SECTOR_ERASE : entry.data;
               end
            endcase
         end
      endcase
   end

endmodule
`default_nettype wire

// [core/flash_bus_cycle.sv]
// one asynchronous flash bus cycle, write or read, timed in clock cycles
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_map.svh"

module flash_bus_cycle
   import flash_cmd_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic start,
   input wire bus_op_t op,
   input wire logic [15:0] dq_in,
   output logic done,
   output logic [15:0] rdata,
   output flash_out_t pins
);

   typedef enum logic [1:0] {cyc_idle, cyc_setup, cyc_strobe, cyc_hold} cyc_state_t;

   cyc_state_t state;
   logic [3:0] count;
   logic is_read;

   // phase sequencer: setup with chip enabled, strobe low, then hold with strobe released
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state <= cyc_idle;
         count <= 4'h0;
         is_read <= 1'b0;
      end else begin
         case (state)
            cyc_idle: begin
               if (start) begin
                  state <= cyc_setup;
                  count <= 4'(`SETUP_CYCLES - 1);
                  is_read <= op.is_read;
               end
            end
            cyc_setup: begin
               if (count == 4'h0) begin
                  state <= cyc_strobe;
                  count <= 4'(`STROBE_CYCLES - 1);
               end else begin
                  count <= count - 4'h1;
               end
            end
            cyc_strobe: begin
               if (count == 4'h0) begin
                  state <= cyc_hold;
                  count <= 4'(`HOLD_CYCLES - 1);
               end else begin
                  count <= count - 4'h1;
               end
            end
            cyc_hold: begin
               if (count == 4'h0) begin
                  state <= cyc_idle;
               end else begin
                  count <= count - 4'h1;
               end
            end
            default: state <= cyc_idle;
         endcase
      end
   end

   // pin drive; address and data stay put through hold so the device latches cleanly
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pins <= '{addr: 21'h0, dq: 16'h0, dq_oe_n: 1'b1, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1};
      end else begin
         if (state == cyc_idle && start) begin
            pins.addr <= op.addr;
            pins.dq <= op.data;
            pins.dq_oe_n <= op.is_read;
            pins.ce_n <= 1'b0;
         end else if (state == cyc_hold && count == 4'h0) begin
            pins.ce_n <= 1'b1;
            pins.dq_oe_n <= 1'b1;
         end
         pins.we_n <= !((state == cyc_setup && count == 4'h0 && !is_read) ||
                        (state == cyc_strobe && count != 4'h0 && !is_read));
         pins.oe_n <= !((state == cyc_setup && count == 4'h0 && is_read) ||
                        (state == cyc_strobe && count != 4'h0 && is_read));
      end
   end

   // read data is sampled at the end of the strobe, before output enable rises
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rdata <= 16'h0;
         done <= 1'b0;
      end else begin
         if (state == cyc_strobe && count == 4'h0 && is_read) begin
            rdata <= dq_in;
         end
         done <= (state == cyc_hold && count == 4'h0);
      end
   end

endmodule
`default_nettype wire

// [core/flash_cmd_host.sv]
// flash command host: software registers in, flash command sequences out on the pins
//
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_map.svh"

module flash_cmd_host
   import flash_cmd_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   input wire logic vpp_high,
   input wire logic [15:0] flash_dq_in,
   output flash_out_t flash_pins,
   output logic flash_reset_n
);

   // ----------------------------------------------------------------
   // state and storage
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {run_idle, run_issue, run_wait} run_state_t;

   run_state_t state;
   cmd_t cmd;
   logic [2:0] step;
   logic [20:0] target;
   logic [20:0] target2;
   logic [15:0] wdata;
   logic [15:0] wdata2;
   logic [15:0] last_rdata;
   logic refused;
   logic id_mode;
   logic pulse_mode;
   logic query_mode;
   logic block_b_locked;
   logic block_b_known;
   logic flash_reset;
   logic config_value;
   step_t entry;
   bus_op_t next_op;
   logic start;
   logic done;
   logic [15:0] cycle_rdata;
   logic cmd_ok;
   cmd_t new_cmd;

   // ----------------------------------------------------------------
   // sequence table and bus cycle engine
   // ----------------------------------------------------------------
   cmd_step_table table_i (
      .cmd(cmd),
      .step(step),
      .entry(entry)
   );

   flash_bus_cycle cycle_i (
      .clk(clk),
      .reset_n(reset_n),
      .start(start),
      .op(next_op),
      .dq_in(flash_dq_in),
      .done(done),
      .rdata(cycle_rdata),
      .pins(flash_pins)
   );

   // ----------------------------------------------------------------
   // request checks
   // ----------------------------------------------------------------
   // a dual word pair must differ only in the lowest word address bit
   function automatic logic dual_pair_ok(input logic [20:0] a, input logic [20:0] b);
      return (a[20:1] == b[20:1]) && (a[0] != b[0]);
   endfunction

   assign new_cmd = cmd_t'(reg_wdata[`CMD_W-1:0]);

   // refuse what the device would reject or misread, so it never sees a bad sequence
   always_comb begin
      case (new_cmd)
         cmd_dual_program: cmd_ok = vpp_high && dual_pair_ok(target, target2);
         cmd_pulse_program: cmd_ok = pulse_mode;
         cmd_set_config: cmd_ok = (wdata[7:1] == 7'h00);
         cmd_read, cmd_chip_erase, cmd_sector_erase, cmd_program, cmd_enter_pulse,
         cmd_lockdown, cmd_suspend, cmd_resume, cmd_id_entry, cmd_id_exit_long,
         cmd_id_exit_short, cmd_prot_program, cmd_prot_lock, cmd_block_b_status,
         cmd_query: cmd_ok = 1'b1;
         default: cmd_ok = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // build the bus operation for the current step
   // ----------------------------------------------------------------
   // fixed command cycles drive zero above the twelve decoded bits and on the upper byte
   always_comb begin
      next_op.is_read = entry.is_read;
      case (entry.asel)
         asel_target: next_op.addr = target;
         asel_target2: next_op.addr = target2;
         asel_prot: next_op.addr = {13'h0000, target[7:0]};
         default: next_op.addr = {9'h000, entry.addr};
      endcase
      case (entry.dsel)
         dsel_user: next_op.data = wdata;
         dsel_user2: next_op.data = wdata2;
         default: next_op.data = {8'h00, entry.data};
      endcase
   end

   assign start = (state == run_issue);

   // ----------------------------------------------------------------
   // sequence runner
   // ----------------------------------------------------------------
   // a sequence is never cut short here; an abandoned one is the device's affair
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state <= run_idle;
         cmd <= cmd_read;
         step <= 3'h0;
      end else begin
         case (state)
            run_idle: begin
               if (reg_write && reg_addr == `REG_CMD && cmd_ok && !flash_reset) begin
                  cmd <= new_cmd;
                  step <= 3'h0;
                  state <= run_issue;
               end
            end
            run_issue: state <= run_wait;
            run_wait: begin
               if (done) begin
                  if (entry.last) begin
                     state <= run_idle;
                  end else begin
                     step <= step + 3'h1;
                     state <= run_issue;
                  end
               end
            end
            default: state <= run_idle;
         endcase
      end
   end

   // refused flag: set on a bad or busy command write, cleared by writing one; set wins
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         refused <= 1'b0;
      end else if (reg_write && reg_addr == `REG_CMD &&
                   (state != run_idle || !cmd_ok || flash_reset)) begin
         refused <= 1'b1;
      end else if (reg_write && reg_addr == `REG_STATUS && reg_wdata[`ST_REFUSED]) begin
         refused <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // tracked device modes
   // ----------------------------------------------------------------
   // mirrors what the device believes; a pin reset returns it to read mode
   always_ff @(posedge clk) begin
      if (!reset_n || flash_reset) begin
         id_mode <= 1'b0;
         pulse_mode <= 1'b0;
         query_mode <= 1'b0;
         config_value <= 1'b0;
      end else if (state == run_wait && done && entry.last) begin
         case (cmd)
            cmd_id_entry, cmd_block_b_status: id_mode <= 1'b1;
            cmd_id_exit_long, cmd_id_exit_short: begin
               id_mode <= 1'b0;
               query_mode <= 1'b0;
            end
            cmd_enter_pulse: pulse_mode <= 1'b1;
            cmd_query: query_mode <= 1'b1;
            cmd_set_config: config_value <= wdata[0];
            default: id_mode <= id_mode;
         endcase
      end
   end

   // read results and the block b lock flag taken from the status read
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         last_rdata <= 16'h0000;
         block_b_locked <= 1'b0;
         block_b_known <= 1'b0;
      end else if (state == run_wait && done && entry.is_read) begin
         last_rdata <= cycle_rdata;
         if (cmd == cmd_block_b_status) begin
            block_b_locked <= !cycle_rdata[`BLOCK_B_FLAG_BIT];
            block_b_known <= 1'b1;
         end
      end else if (state == run_wait && done && cmd == cmd_prot_lock) begin
         block_b_known <= 1'b0; // stale until read back
      end
   end

   // ----------------------------------------------------------------
   // software registers
   // ----------------------------------------------------------------
   // operands are not locked against a running command; software waits on busy
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         target <= 21'h000000;
         target2 <= 21'h000000;
         wdata <= 16'h0000;
         wdata2 <= 16'h0000;
         flash_reset <= `CTRL_RESET_VALUE;
      end else if (reg_write) begin
         case (reg_addr)
            `REG_ADDR: target <= reg_wdata[20:0];
            `REG_DATA: wdata <= reg_wdata[15:0];
            `REG_DATA2: begin
               wdata2 <= reg_wdata[15:0];
               target2 <= {target[20:1], !target[0]};
            end
            `REG_CTRL: flash_reset <= reg_wdata[`CTRL_FLASH_RESET];
            default: flash_reset <= flash_reset;
         endcase
      end
   end

   // device reset pin follows the control bit; the device clears lockdown on it
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         flash_reset_n <= 1'b0;
      end else begin
         flash_reset_n <= !flash_reset;
      end
   end

   // read data stand in the cycle after the read strobe; unmapped reads give zero
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         reg_rdata <= 32'h00000000;
      end else if (reg_read) begin
         case (reg_addr)
            `REG_CMD: reg_rdata <= {27'h0000000, cmd};
            `REG_ADDR: reg_rdata <= {11'h000, target};
            `REG_DATA: reg_rdata <= {16'h0000, wdata};
            `REG_DATA2: reg_rdata <= {16'h0000, wdata2};
            `REG_STATUS: reg_rdata <= {24'h000000, config_value, block_b_known, block_b_locked,
                                       query_mode, pulse_mode, id_mode, refused,
                                       state != run_idle};
            `REG_RDATA: reg_rdata <= {16'h0000, last_rdata};
            `REG_CTRL: reg_rdata <= {31'h00000000, flash_reset};
            default: reg_rdata <= 32'h00000000;
         endcase
      end else begin
         reg_rdata <= 32'h00000000;
      end
   end

endmodule
`default_nettype wire

// [test/flash_cmd_host_properties.sv]
// concurrent checks on the flash command host ports
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_host_checker
   import flash_cmd_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic reg_read,
   input wire logic [31:0] reg_rdata,
   input wire flash_out_t flash_pins,
   input wire logic flash_reset_n
);
   wire logic we_n = flash_pins.we_n;
   wire logic ce_n = flash_pins.ce_n;
   wire logic [11:0] ad = flash_pins.addr[11:0];
   wire logic [7:0] dl = flash_pins.dq[7:0];
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // ----
   // unlock pair, strobe shape, register port
   // ----
   sequence unl1;
      $fell(we_n) && ad == 12'h555 && dl == 8'haa;
   endsequence
   sequence unl2;
      $fell(we_n) && ad == 12'haaa && dl == 8'h55;
   endsequence
   a_unlock_pair: assert property (unl1 |-> ##[1:20] unl2)
      else $error("second unlock write missing");
   a_cmd_high_zero: assert property (unl1 |-> flash_pins.dq[15:8] == 8'h00 && flash_pins.addr[20:12] == 9'h000)
      else $error("command write upper bits not zero");
   a_we_two_low: assert property ($fell(we_n) |=> !we_n ##1 we_n)
      else $error("write strobe width wrong");
   a_strobe_in_ce: assert property (!we_n |-> !ce_n && !flash_pins.dq_oe_n)
      else $error("write strobe outside a driven selected cycle");
   a_read_released: assert property (!flash_pins.oe_n |-> flash_pins.dq_oe_n && we_n)
      else $error("read cycle with data driven");
   a_pins_stable: assert property (!ce_n && $past(ce_n) == 1'b0 |-> $stable(flash_pins.addr) && $stable(flash_pins.dq))
      else $error("address or data moved inside a cycle");
   a_reset_release: assert property ($rose(reset_n) |=> flash_reset_n)
      else $error("flash reset pin held after release");
   a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
      else $error("read data outside its cycle");
endmodule
bind flash_cmd_host flash_cmd_host_checker flash_cmd_host_checker_i(.clk(clk), .reset_n(reset_n),
   .reg_read(reg_read), .reg_rdata(reg_rdata), .flash_pins(flash_pins), .flash_reset_n(flash_reset_n));
`default_nettype wire

// [test/flash_dev_model.sv]
// behavioural flash device on the far side of the command host
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model
   import flash_cmd_pkg::*;
(
   input wire flash_out_t pins,
   input wire logic rst_n,
   output logic [15:0] dq
);
   int wq[$]; // writes as {addr,data}, drained by the bench
   logic id = 1'b0, lk = 1'b0;
   logic [7:0] prev = 8'h00, cfg = 8'h00;
   logic [15:0] rv;
   // ----
   // decode on the closing write strobe; block b lock is one-time, reset leaves it
   // ----
   always @(posedge pins.we_n or negedge rst_n) begin
      if (!rst_n) begin
         id <= 1'b0;
      end else if (!pins.ce_n) begin
         wq.push_back({pins.addr[11:0], pins.dq[7:0]});
         if (id) id <= 1'b0;
         else if (pins.dq[7:0] == 8'h90 && pins.addr[11:0] == 12'h555) id <= 1'b1;
         if (prev == 8'hc0 && pins.addr[11:0] == 12'h080 && pins.dq[3:0] == 4'h0) lk <= 1'b1;
         if (prev == 8'hd0) cfg <= pins.dq[7:0];
         prev <= pins.dq[7:0];
      end
   end
   // released bus shows the inverse so a stale value never passes
   assign rv = (id && pins.addr[11:0] == 12'h080) ? {14'h0, ~lk, 1'b0} : pins.addr[15:0] ^ 16'ha5c3;
   assign dq = (!pins.oe_n && !pins.ce_n) ? rv : ~rv;
endmodule
`default_nettype wire

// [test/testbench.sv]
// self-checking bench for the flash command host
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_map.svh"
module testbench
   import flash_cmd_pkg::*;
;
   logic clk = 0, reset_n = 0, reg_write = 0, reg_read = 0, vpp_high = 0, flash_reset_n;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, rd;
   logic [20:0] a;
   logic [15:0] d, dq_in;
   flash_out_t flash_pins;
   int miscompares = 0, num_checks = 0, lf = 79107;
   localparam int U1 = 20'h555aa, U2 = 20'haaa55, E = 20'h55580;
   flash_cmd_host flash_cmd_host_i(.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .vpp_high(vpp_high),
      .flash_dq_in(dq_in), .flash_pins(flash_pins), .flash_reset_n(flash_reset_n));
   flash_dev_model flash_dev_model_i(.pins(flash_pins), .rst_n(flash_reset_n), .dq(dq_in));
   initial forever #20 clk = ~clk;
   // ----
   // bus tasks and the expected-write model
   // ----
   function automatic int lfsr(int s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         miscompares++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   // strobe drops one edge later, so back-to-back calls never assign it twice in a step
   task automatic wr(logic [7:0] ra, logic [31:0] v);
      reg_addr <= ra;
      reg_wdata <= v;
      reg_write <= 1'b1;
      @(posedge clk) reg_write <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rdr(logic [7:0] ra);
      reg_addr <= ra;
      reg_read <= 1'b1;
      @(posedge clk) reg_read <= 1'b0;
      @(posedge clk) rd = reg_rdata;
   endtask
   // issue one command and compare every write the device saw with the expected list
   task automatic run(cmd_t c, int e[$], string n);
      wr(`REG_ADDR, {11'h0, a});
      wr(`REG_DATA, {16'h0, d});
      wr(`REG_DATA2, {16'h0, ~d});
      wr(`REG_CMD, {27'h0, c});
      rd = 32'h1;
      for (int i = 0; i < 200 && rd[0] !== 1'b0; i++) rdr(`REG_STATUS);
      chk({n, " count"}, e.size(), flash_dev_model_i.wq.size());
      foreach (e[i]) chk(n, e[i], flash_dev_model_i.wq[i]);
      flash_dev_model_i.wq.delete();
      $display("done %s", n);
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      test_done();
   end
   initial begin
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      lf = lfsr(lf);
      a = {lf[20:1], 1'b0};
      d = lf[15:0];
      run(cmd_chip_erase, '{U1, U2, E, U1, U2, 20'h55510}, "chip erase");
      run(cmd_sector_erase, '{U1, U2, E, U1, U2, {a[11:0], 8'h30}}, "sector erase");
      run(cmd_program, '{U1, U2, 20'h555a0, {a[11:0], d[7:0]}}, "program");
      run(cmd_lockdown, '{U1, U2, E, U1, U2, {a[11:0], 8'h60}}, "lockdown");
      run(cmd_suspend, '{20'h000b0}, "suspend");
      run(cmd_resume, '{20'h00030}, "resume");
      run(cmd_prot_program, '{U1, U2, 20'h555c0, {4'h0, a[7:0], d[7:0]}}, "prot program");
      run(cmd_prot_lock, '{U1, U2, 20'h555c0, 20'h08000}, "prot lock");
      run(cmd_block_b_status, '{U1, U2, 20'h55590}, "block status");
      rdr(`REG_RDATA);
      chk("block b word", 32'h0, rd);
      rdr(`REG_STATUS);
      chk("status", 32'h64, rd);
      run(cmd_id_exit_short, '{20'h000f0}, "short exit");
      run(cmd_id_entry, '{U1, U2, 20'h55590}, "id entry");
      run(cmd_id_exit_long, '{U1, U2, 20'h555f0}, "long exit");
      run(cmd_query, '{20'h05598}, "query");
      chk("query status", 32'h70, rd);
      run(cmd_read, '{}, "read");
      rdr(`REG_RDATA);
      chk("read word", {16'h0, a[15:0] ^ 16'ha5c3}, rd);
      run(cmd_dual_program, '{}, "dual refused");
      rdr(`REG_STATUS);
      chk("refused", 1'b1, rd[1]);
      wr(`REG_STATUS, 32'h2);
      vpp_high <= 1'b1;
      run(cmd_dual_program, '{U1, U2, 20'h555e0, {a[11:0], d[7:0]}, {a[11:1], 1'b1, ~d[7:0]}}, "dual");
      run(cmd_enter_pulse, '{U1, U2, E, U1, U2, 20'h555a0}, "pulse entry");
      chk("pulse mode", 1'b1, rd[3]);
      run(cmd_pulse_program, '{{a[11:0], d[7:0]}}, "pulse program");
      rdr(8'hfc);
      chk("unmapped", 32'h0, rd);
      wr(`REG_CTRL, 32'h1);
      @(posedge clk);
      chk("flash reset", 1'b0, flash_reset_n);
      wr(`REG_CTRL, 32'h0);
      a = 21'h0;
      d = 16'h1;
      run(cmd_set_config, '{U1, U2, 20'h555d0, 20'h00001}, "config");
      chk("config", 1'b1, rd[7]);
      chk("config dev", 8'h01, flash_dev_model_i.cfg);
      test_done();
   end
endmodule
`default_nettype wire
